// ===== gyr_addr_seq.sv
// auto-increment pointer successor for the register map
`timescale 1ns/10ps
`include "gyr_regs.svh"
module gyr_addr_seq (
	input  wire gyr_pkg::gyr_byte_t i_cur_addr,
	input  wire logic               i_wrap_first,
	output gyr_pkg::gyr_byte_t      o_next_addr
);
	function automatic gyr_pkg::gyr_byte_t gyr_next(input gyr_pkg::gyr_byte_t a,
		input logic w);
		gyr_pkg::gyr_byte_t n;
		n = a + 8'h01;
		if (a == `GYR_ADDR_RATE_Z_LOW) begin
			n = w ? `GYR_ADDR_RATE_X_HIGH : `GYR_ADDR_STATUS_ALIAS;
		end else if (a == `GYR_ADDR_CTRL_INC_POWER) begin
			n = `GYR_ADDR_STATUS_ALIAS;
		end
		return n;
	endfunction : gyr_next

	assign o_next_addr = gyr_next(i_cur_addr, i_wrap_first);
endmodule : gyr_addr_seq

// ===== gyr_host_model.sv
// host processor model issuing register accesses to the map
`timescale 1ns/10ps
module gyr_host_model (
	input  wire logic               i_sys_clk,
	input  wire gyr_pkg::gyr_byte_t i_rd_data,
	input  wire logic               i_rd_valid,
	input  wire logic               i_fifo_pop,
	output logic                    o_acc_begin,
	output gyr_pkg::gyr_byte_t      o_acc_addr,
	output logic                    o_acc_rd,
	output logic                    o_acc_wr,
	output gyr_pkg::gyr_byte_t      o_acc_wdata
);
	initial begin
		o_acc_begin = 1'b0;
		o_acc_addr  = 8'h00;
		o_acc_rd    = 1'b0;
		o_acc_wr    = 1'b0;
		o_acc_wdata = 8'h00;
	end
	// one byte access, called just after a rising edge, returns just after the next one
	task automatic access(input logic beg, input logic [7:0] a, input logic wr,
		input logic [7:0] wd, output logic [7:0] d, output logic v, output logic p);
		o_acc_begin = beg;
		o_acc_addr  = a;
		o_acc_rd    = !wr;
		o_acc_wr    = wr;
		o_acc_wdata = wd;
		#1;
		p = i_fifo_pop;
		@(posedge i_sys_clk);
		#1;
		v = i_rd_valid;
		d = i_rd_data;
	endtask : access
	// release: strobes low, address and data lines show the inverse of their last value
	task automatic idle();
		o_acc_begin = 1'b0;
		o_acc_rd    = 1'b0;
		o_acc_wr    = 1'b0;
		o_acc_addr  = ~o_acc_addr;
		o_acc_wdata = ~o_acc_wdata;
		@(posedge i_sys_clk);
		#1;
	endtask : idle
endmodule : gyr_host_model

// ===== gyr_out_if.sv
// read events and output data byte between the map and the output data registers
`timescale 1ns/10ps
interface gyr_out_if;
	logic               rd_fire;
	gyr_pkg::gyr_byte_t rd_addr;
	logic               fifo_on;
	gyr_pkg::gyr_byte_t byte_out;
	logic               pop;
	modport map_side (output rd_fire, output rd_addr, output fifo_on, input byte_out, input pop);
	modport out_side (input rd_fire, input rd_addr, input fifo_on, output byte_out, output pop);
endinterface : gyr_out_if

// ===== gyr_out_regs.sv
// output data registers: live sample in direct mode, fifo head snapshot otherwise
`timescale 1ns/10ps
`include "gyr_regs.svh"
module gyr_out_regs (
	input  wire logic               i_sys_clk,
	input  wire logic               i_sys_rst,
	input  wire logic               i_sample_valid,
	input  wire gyr_pkg::gyr_word_t i_sample_x,
	input  wire gyr_pkg::gyr_word_t i_sample_y,
	input  wire gyr_pkg::gyr_word_t i_sample_z,
	input  wire gyr_pkg::gyr_word_t i_head_x,
	input  wire gyr_pkg::gyr_word_t i_head_y,
	input  wire gyr_pkg::gyr_word_t i_head_z,
	gyr_out_if.out_side             bus
);
	logic [47:0] live_r;
	logic [23:0] low_hold_r;
	logic [47:0] snap_r;
	wire  [47:0] head_w = {i_head_x, i_head_y, i_head_z};
	wire  [2:0]  axis_w = 3'((bus.rd_addr - 8'h01) >> 1);
	wire         is_out_w = (bus.rd_addr >= `GYR_ADDR_RATE_X_HIGH) &&
		(bus.rd_addr <= `GYR_ADDR_RATE_Z_LOW);
	wire         is_high_w = is_out_w && bus.rd_addr[0];
	wire         load_head_w = bus.rd_fire && bus.fifo_on &&
		(bus.rd_addr == `GYR_ADDR_RATE_X_HIGH);
	wire  [7:0]  live_hi_w = live_r[47 - 16*axis_w -: 8];
	wire  [7:0]  live_lo_w = live_r[39 - 16*axis_w -: 8];
	wire  [7:0]  hold_w    = low_hold_r[23 - 8*axis_w -: 8];
	wire  [7:0]  snap_w    = snap_r[47 - 8*(bus.rd_addr - 8'h01) -: 8];

	assign bus.pop = bus.rd_fire && bus.fifo_on && (bus.rd_addr == `GYR_ADDR_RATE_Z_HIGH);
	assign bus.byte_out = !is_out_w ? 8'h00 :
		load_head_w ? i_head_x[15:8] :
		bus.fifo_on ? snap_w :
		is_high_w ? live_hi_w : hold_w;

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			live_r     <= 48'h0;
			low_hold_r <= 24'h0;
			snap_r     <= 48'h0;
		end else begin
			if (i_sample_valid && !bus.fifo_on) live_r <= {i_sample_x, i_sample_y, i_sample_z};
			if (bus.rd_fire && !bus.fifo_on && is_high_w) low_hold_r[23 - 8*axis_w -: 8] <= live_lo_w;
			if (load_head_w) snap_r <= head_w;
		end
	end

	default clocking gyr_cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	por_zero_a: assert property ($past(i_sys_rst) |-> live_r == 48'h0 && snap_r == 48'h0)
		else $error("output data not zero after reset");
endmodule : gyr_out_regs

// ===== gyr_pkg.sv
// shared types of the rate sensor register map
package gyr_pkg;
	typedef logic [7:0]  gyr_byte_t;
	typedef logic [15:0] gyr_word_t;
	typedef logic [1:0]  gyr_fifo_mode_t;
endpackage : gyr_pkg

// ===== gyr_reg_map.sv
// rate sensor register map with auto-increment pointer and status alias
// Function
// - a burst step after the z-axis low byte goes to 0x00, or to 0x01 when wrap_to_first_sample is set.
// - a burst step after the last control register at 0x15 goes back to 0x00.
// - reserved addresses 0x16 to 0xFF read zero and, like plain registers, step to address plus one.
// - address 0x00 reads a copy of the sample-ready flags or of the fifo state, picked by fifo mode.
// - a burst from 0x00 gives the status byte and then the current or oldest buffered sample.
// - the six rate output registers read 0x00 after power-on reset and keep their values through soft reset.
// - on reset the writable registers load 0x00, the debounce count loads 0x01, identity is fixed.
// - only fifo setup, the four controls and the threshold config, level and count are writable.
// - fifo mode 0b00 updates the outputs at the data rate, larger values present the fifo head.
`timescale 1ns/10ps
`include "gyr_regs.svh"
module gyr_reg_map #(
	parameter gyr_pkg::gyr_byte_t IDENTITY_CODE = 8'h5A  // arbitrary value
) (
	input  wire logic               i_sys_clk,
	input  wire logic               i_sys_rst,
	input  wire logic               i_soft_rst,
	input  wire logic               i_acc_begin,
	input  wire gyr_pkg::gyr_byte_t i_acc_addr,
	input  wire logic               i_acc_rd,
	input  wire logic               i_acc_wr,
	input  wire gyr_pkg::gyr_byte_t i_acc_wdata,
	output gyr_pkg::gyr_byte_t      o_rd_data,
	output logic                    o_rd_valid,
	output gyr_pkg::gyr_byte_t      o_acc_ptr,
	input  wire logic               i_sample_valid,
	input  wire gyr_pkg::gyr_word_t i_sample_x,
	input  wire gyr_pkg::gyr_word_t i_sample_y,
	input  wire gyr_pkg::gyr_word_t i_sample_z,
	input  wire gyr_pkg::gyr_word_t i_head_x,
	input  wire gyr_pkg::gyr_word_t i_head_y,
	input  wire gyr_pkg::gyr_word_t i_head_z,
	output logic                    o_fifo_pop,
	input  wire gyr_pkg::gyr_byte_t i_sample_ready_flags,
	input  wire gyr_pkg::gyr_byte_t i_fifo_state,
	input  wire gyr_pkg::gyr_byte_t i_fifo_event_flags,
	input  wire gyr_pkg::gyr_byte_t i_irq_source_flags,
	input  wire gyr_pkg::gyr_byte_t i_threshold_event_flags,
	input  wire gyr_pkg::gyr_byte_t i_die_temperature,
	output gyr_pkg::gyr_byte_t      o_fifo_config,
	output gyr_pkg::gyr_byte_t      o_control_range_filter,
	output gyr_pkg::gyr_byte_t      o_threshold_config,
	output gyr_pkg::gyr_byte_t      o_threshold_level,
	output gyr_pkg::gyr_byte_t      o_threshold_debounce_count,
	output gyr_pkg::gyr_byte_t      o_control_mode_rate,
	output gyr_pkg::gyr_byte_t      o_control_irq,
	output gyr_pkg::gyr_byte_t      o_control_increment_power
);
	gyr_pkg::gyr_byte_t ptr_r;
	gyr_pkg::gyr_byte_t rd_data_r;
	logic               rd_valid_r;
	gyr_pkg::gyr_byte_t fifo_config_r;
	gyr_pkg::gyr_byte_t range_filter_r;
	gyr_pkg::gyr_byte_t thr_config_r;
	gyr_pkg::gyr_byte_t thr_level_r;
	gyr_pkg::gyr_byte_t thr_debounce_r;
	gyr_pkg::gyr_byte_t mode_rate_r;
	gyr_pkg::gyr_byte_t ctrl_irq_r;
	gyr_pkg::gyr_byte_t inc_power_r;
	gyr_pkg::gyr_byte_t next_addr_w;
	gyr_pkg::gyr_byte_t rd_mux_w;

	gyr_out_if out_bus ();

	// access address: a fresh start address wins over the running pointer
	wire gyr_pkg::gyr_byte_t     acc_addr_w = i_acc_begin ? i_acc_addr : ptr_r;
	wire                         acc_fire_w = i_acc_rd || i_acc_wr;
	wire                         rd_fire_w  = i_acc_rd && !i_acc_wr;
	wire                         wr_fire_w  = i_acc_wr;
	wire gyr_pkg::gyr_fifo_mode_t fifo_mode_w =
		fifo_config_r[`GYR_FIFO_MODE_MSB:`GYR_FIFO_MODE_LSB];
	wire                         fifo_on_w  = fifo_mode_w != `GYR_FIFO_MODE_OFF;
	wire                         wrap_first_w = inc_power_r[`GYR_WRAP_FIRST_BIT];
	wire gyr_pkg::gyr_byte_t     status_alias_w = fifo_on_w ? i_fifo_state
		: i_sample_ready_flags;
	wire                         is_rate_w = (acc_addr_w >= `GYR_ADDR_RATE_X_HIGH) &&
		(acc_addr_w <= `GYR_ADDR_RATE_Z_LOW);

	// write decode: only the writable registers have a strobe
	wire wr_fifo_config_w  = wr_fire_w && (acc_addr_w == `GYR_ADDR_FIFO_CONFIG);
	wire wr_range_w        = wr_fire_w && (acc_addr_w == `GYR_ADDR_CTRL_RANGE);
	wire wr_thr_config_w   = wr_fire_w && (acc_addr_w == `GYR_ADDR_THR_CONFIG);
	wire wr_thr_level_w    = wr_fire_w && (acc_addr_w == `GYR_ADDR_THR_LEVEL);
	wire wr_thr_debounce_w = wr_fire_w && (acc_addr_w == `GYR_ADDR_THR_DEBOUNCE);
	wire wr_mode_rate_w    = wr_fire_w && (acc_addr_w == `GYR_ADDR_CTRL_MODE_RATE);
	wire wr_ctrl_irq_w     = wr_fire_w && (acc_addr_w == `GYR_ADDR_CTRL_IRQ);
	wire wr_inc_power_w    = wr_fire_w && (acc_addr_w == `GYR_ADDR_CTRL_INC_POWER);

	gyr_addr_seq u_addr_seq (
		.i_cur_addr   (acc_addr_w),
		.i_wrap_first (wrap_first_w),
		.o_next_addr  (next_addr_w)
	);

	assign out_bus.rd_fire = rd_fire_w;
	assign out_bus.rd_addr = acc_addr_w;
	assign out_bus.fifo_on = fifo_on_w;

	gyr_out_regs u_out_regs (
		.i_sys_clk      (i_sys_clk),
		.i_sys_rst      (i_sys_rst),
		.i_sample_valid (i_sample_valid),
		.i_sample_x     (i_sample_x),
		.i_sample_y     (i_sample_y),
		.i_sample_z     (i_sample_z),
		.i_head_x       (i_head_x),
		.i_head_y       (i_head_y),
		.i_head_z       (i_head_z),
		.bus            (out_bus.out_side)
	);

	assign o_fifo_pop = out_bus.pop;

	// read selection
	always_comb begin
		rd_mux_w = `GYR_RST_DEFAULT;
		if (is_rate_w) begin
			rd_mux_w = out_bus.byte_out;
		end else begin
			case (acc_addr_w)
				`GYR_ADDR_STATUS_ALIAS:   rd_mux_w = status_alias_w;
				`GYR_ADDR_SAMPLE_READY:   rd_mux_w = i_sample_ready_flags;
				`GYR_ADDR_FIFO_STATE:     rd_mux_w = i_fifo_state;
				`GYR_ADDR_FIFO_CONFIG:    rd_mux_w = fifo_config_r;
				`GYR_ADDR_FIFO_EVENT:     rd_mux_w = i_fifo_event_flags;
				`GYR_ADDR_IRQ_SOURCE:     rd_mux_w = i_irq_source_flags;
				`GYR_ADDR_IDENTITY:       rd_mux_w = IDENTITY_CODE;
				`GYR_ADDR_CTRL_RANGE:     rd_mux_w = range_filter_r;
				`GYR_ADDR_THR_CONFIG:     rd_mux_w = thr_config_r;
				`GYR_ADDR_THR_EVENT:      rd_mux_w = i_threshold_event_flags;
				`GYR_ADDR_THR_LEVEL:      rd_mux_w = thr_level_r;
				`GYR_ADDR_THR_DEBOUNCE:   rd_mux_w = thr_debounce_r;
				`GYR_ADDR_TEMPERATURE:    rd_mux_w = i_die_temperature;
				`GYR_ADDR_CTRL_MODE_RATE: rd_mux_w = mode_rate_r;
				`GYR_ADDR_CTRL_IRQ:       rd_mux_w = ctrl_irq_r;
				`GYR_ADDR_CTRL_INC_POWER: rd_mux_w = inc_power_r;
				default:                  rd_mux_w = `GYR_RST_DEFAULT;
			endcase
		end
	end

	// pointer and read data
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			ptr_r      <= `GYR_ADDR_STATUS_ALIAS;
			rd_data_r  <= `GYR_RST_DEFAULT;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= rd_fire_w;
			if (rd_fire_w) rd_data_r <= rd_mux_w;
			if (acc_fire_w) begin
				ptr_r <= next_addr_w;
			end else if (i_acc_begin) begin
				ptr_r <= i_acc_addr;
			end
		end
	end

	// writable registers; soft reset reloads them but leaves output data alone
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst || i_soft_rst) begin
			fifo_config_r  <= `GYR_RST_DEFAULT;
			range_filter_r <= `GYR_RST_DEFAULT;
			thr_config_r   <= `GYR_RST_DEFAULT;
			thr_level_r    <= `GYR_RST_DEFAULT;
			thr_debounce_r <= `GYR_RST_THR_DEBOUNCE;
			mode_rate_r    <= `GYR_RST_DEFAULT;
			ctrl_irq_r     <= `GYR_RST_DEFAULT;
			inc_power_r    <= `GYR_RST_DEFAULT;
		end else begin
			if (wr_fifo_config_w)  fifo_config_r  <= i_acc_wdata;
			if (wr_range_w)        range_filter_r <= i_acc_wdata;
			if (wr_thr_config_w)   thr_config_r   <= i_acc_wdata;
			if (wr_thr_level_w)    thr_level_r    <= i_acc_wdata;
			if (wr_thr_debounce_w) thr_debounce_r <= i_acc_wdata;
			if (wr_mode_rate_w)    mode_rate_r    <= i_acc_wdata;
			if (wr_ctrl_irq_w)     ctrl_irq_r     <= i_acc_wdata;
			if (wr_inc_power_w)    inc_power_r    <= i_acc_wdata;
		end
	end

	assign o_rd_data                  = rd_data_r;
	assign o_rd_valid                 = rd_valid_r;
	assign o_acc_ptr                  = ptr_r;
	assign o_fifo_config              = fifo_config_r;
	assign o_control_range_filter     = range_filter_r;
	assign o_threshold_config         = thr_config_r;
	assign o_threshold_level          = thr_level_r;
	assign o_threshold_debounce_count = thr_debounce_r;
	assign o_control_mode_rate        = mode_rate_r;
	assign o_control_irq              = ctrl_irq_r;
	assign o_control_increment_power  = inc_power_r;

	// checks
	default clocking gyr_cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	sequence status_read_s;
		rd_fire_w && !i_soft_rst && (acc_addr_w == `GYR_ADDR_STATUS_ALIAS);
	endsequence
	sequence next_is_x_high_s;
		##1 (ptr_r == `GYR_ADDR_RATE_X_HIGH);
	endsequence

	wrap_to_zero_a: assert property (
		acc_fire_w && acc_addr_w == `GYR_ADDR_RATE_Z_LOW && !wrap_first_w
		|=> ptr_r == `GYR_ADDR_STATUS_ALIAS)
		else $error("z low byte did not step to 0x00");
	wrap_to_one_a: assert property (
		acc_fire_w && acc_addr_w == `GYR_ADDR_RATE_Z_LOW && wrap_first_w
		|=> ptr_r == `GYR_ADDR_RATE_X_HIGH)
		else $error("z low byte did not step to 0x01");
	ctrl_wrap_a: assert property (
		acc_fire_w && acc_addr_w == `GYR_ADDR_CTRL_INC_POWER |=> ptr_r == `GYR_ADDR_STATUS_ALIAS)
		else $error("last control register did not wrap to 0x00");
	reserved_step_a: assert property (
		acc_fire_w && acc_addr_w >= `GYR_ADDR_RESERVED_FIRST
		|=> ptr_r == 8'($past(acc_addr_w) + 8'h01) && !(rd_valid_r && rd_data_r != 8'h00))
		else $error("reserved address stepped or read wrongly");
	status_alias_a: assert property (
		status_read_s |=> rd_valid_r && rd_data_r == $past(status_alias_w)
		&& ($past(fifo_on_w) ? rd_data_r == $past(i_fifo_state)
		: rd_data_r == $past(i_sample_ready_flags)))
		else $error("status alias returned the wrong source");
	burst_from_status_a: assert property (status_read_s |-> next_is_x_high_s)
		else $error("burst from status did not continue at x high");
	reset_values_a: assert property (
		($past(i_soft_rst) || $past(i_sys_rst))
		|-> thr_debounce_r == 8'h01 && fifo_config_r == 8'h00
		&& inc_power_r == 8'h00 && mode_rate_r == 8'h00 && range_filter_r == 8'h00
		&& thr_config_r == 8'h00 && thr_level_r == 8'h00 && ctrl_irq_r == 8'h00)
		else $error("reset values wrong");
	ro_write_a: assert property (
		wr_fire_w && !i_soft_rst && (acc_addr_w < `GYR_ADDR_FIFO_CONFIG
		|| acc_addr_w == `GYR_ADDR_FIFO_EVENT || acc_addr_w == `GYR_ADDR_IRQ_SOURCE
		|| acc_addr_w == `GYR_ADDR_IDENTITY || acc_addr_w == `GYR_ADDR_THR_EVENT
		|| acc_addr_w == `GYR_ADDR_TEMPERATURE || acc_addr_w >= `GYR_ADDR_RESERVED_FIRST)
		|=> $stable(fifo_config_r) && $stable(thr_level_r) && $stable(inc_power_r)
		&& $stable(thr_debounce_r) && $stable(mode_rate_r) && $stable(range_filter_r)
		&& $stable(thr_config_r) && $stable(ctrl_irq_r))
		else $error("write to read-only address changed a register");
	rw_write_a: assert property (
		wr_fire_w && !i_soft_rst && acc_addr_w == `GYR_ADDR_THR_LEVEL
		|=> thr_level_r == $past(i_acc_wdata))
		else $error("threshold level write lost");
	fifo_head_a: assert property (
		rd_fire_w && fifo_on_w && acc_addr_w == `GYR_ADDR_RATE_X_HIGH
		|=> rd_data_r == $past(i_head_x[15:8]))
		else $error("fifo mode x high not taken from fifo head");
	fifo_pop_a: assert property (
		o_fifo_pop |-> rd_fire_w && fifo_on_w && acc_addr_w == `GYR_ADDR_RATE_Z_HIGH)
		else $error("fifo pop without z high read");
endmodule : gyr_reg_map

// ===== gyr_register_map_autoinc_test.sv
// self-checking testbench of the rate sensor register map
`timescale 1ns/10ps
module gyr_register_map_autoinc_test;
	localparam gyr_pkg::gyr_byte_t IDC    = 8'h3C;  // arbitrary value
	localparam logic [7:0]         WA [8] = '{8'h09, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h13, 8'h14, 8'h15};
	logic               i_sys_clk;
	logic               i_sys_rst;
	logic               soft_rst;
	logic               smp_vld;
	logic               acc_begin, acc_rd, acc_wr, rd_valid, fifo_pop;
	gyr_pkg::gyr_byte_t acc_addr, acc_wdata, rd_data, acc_ptr;
	gyr_pkg::gyr_word_t smp [3];
	gyr_pkg::gyr_word_t head [3];
	gyr_pkg::gyr_word_t live [3];
	gyr_pkg::gyr_byte_t sts [6];
	gyr_pkg::gyr_byte_t outs [8];
	logic [7:0]         shd [22];
	int                 error_cnt;
	int                 checks;

	gyr_reg_map #(.IDENTITY_CODE(IDC)) gyr_reg_map_inst (.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst), .i_soft_rst(soft_rst), .i_acc_begin(acc_begin),
		.i_acc_addr(acc_addr), .i_acc_rd(acc_rd), .i_acc_wr(acc_wr), .i_acc_wdata(acc_wdata),
		.o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_acc_ptr(acc_ptr),
		.i_sample_valid(smp_vld), .i_sample_x(smp[0]), .i_sample_y(smp[1]),
		.i_sample_z(smp[2]), .i_head_x(head[0]), .i_head_y(head[1]), .i_head_z(head[2]),
		.o_fifo_pop(fifo_pop), .i_sample_ready_flags(sts[0]), .i_fifo_state(sts[1]),
		.i_fifo_event_flags(sts[2]), .i_irq_source_flags(sts[3]),
		.i_threshold_event_flags(sts[4]), .i_die_temperature(sts[5]),
		.o_fifo_config(outs[0]), .o_control_range_filter(outs[1]),
		.o_threshold_config(outs[2]), .o_threshold_level(outs[3]),
		.o_threshold_debounce_count(outs[4]), .o_control_mode_rate(outs[5]),
		.o_control_irq(outs[6]), .o_control_increment_power(outs[7]));
	gyr_host_model gyr_host_model_inst (.i_sys_clk(i_sys_clk), .i_rd_data(rd_data),
		.i_rd_valid(rd_valid), .i_fifo_pop(fifo_pop), .o_acc_begin(acc_begin),
		.o_acc_addr(acc_addr), .o_acc_rd(acc_rd), .o_acc_wr(acc_wr), .o_acc_wdata(acc_wdata));

	initial begin
		i_sys_clk = 1'b0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	task automatic close_out();
		if (error_cnt == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	function automatic logic fon();
		return shd[9][7:6] != 2'h0;
	endfunction : fon
	function automatic logic [7:0] nxt(input logic [7:0] a);
		if (a == 8'h06) return shd[21][3] ? 8'h01 : 8'h00;
		if (a == 8'h15) return 8'h00;
		return a + 8'h01;
	endfunction : nxt
	function automatic logic [7:0] exp_of(input logic [7:0] a);
		logic [15:0] w;
		w = 16'h0000;
		if (a >= 8'h01 && a <= 8'h06) w = fon() ? head[(a - 8'h01) >> 1] : live[(a - 8'h01) >> 1];
		case (a)
			8'h00: return fon() ? sts[1] : sts[0];
			8'h01, 8'h03, 8'h05: return w[15:8];
			8'h02, 8'h04, 8'h06: return w[7:0];
			8'h07: return sts[0];
			8'h08: return sts[1];
			8'h0A: return sts[2];
			8'h0B: return sts[3];
			8'h0C: return IDC;
			8'h0F: return sts[4];
			8'h12: return sts[5];
			default: return (a < 8'h16) ? shd[a[4:0]] : 8'h00;
		endcase
	endfunction : exp_of
	task automatic t_burst(input logic [7:0] start, input int n);
		logic [7:0] a;
		logic [7:0] d;
		logic       v;
		logic       p;
		a = start;
		for (int k = 0; k < n; k++) begin
			gyr_host_model_inst.access(k == 0, a, 1'b0, 8'h00, d, v, p);
			check("fifo_pop", {7'h00, p}, {7'h00, fon() && a == 8'h05});
			check("rd_valid", {7'h00, v}, 8'h01);
			check("rd_data", d, exp_of(a));
			check("acc_ptr", acc_ptr, nxt(a));
			a = nxt(a);
		end
		gyr_host_model_inst.idle();
	endtask : t_burst
	task automatic t_write(input logic [7:0] a, input logic [7:0] wd);
		logic [7:0] d;
		logic       v;
		logic       p;
		gyr_host_model_inst.access(1'b1, a, 1'b1, wd, d, v, p);
		if (a inside {WA}) shd[a[4:0]] = wd;
		check("wr_ptr", acc_ptr, nxt(a));
		gyr_host_model_inst.idle();
	endtask : t_write
	task automatic t_outs();
		for (int k = 0; k < 8; k++) check("ctl_out", outs[k], shd[WA[k][4:0]]);
	endtask : t_outs
	task automatic pulse_smp();
		smp_vld = 1'b1;
		@(posedge i_sys_clk);
		#1;
		smp_vld = 1'b0;
		if (!fon()) live = smp;
	endtask : pulse_smp
	task automatic t_defaults();
		t_outs();
		t_burst(8'h00, 8);
		t_burst(8'h07, 16);
	endtask : t_defaults
	task automatic t_reserved();
		t_write(8'h20, 8'h5A);
		t_burst(8'h1F, 2);
		t_burst(8'hFF, 2);
	endtask : t_reserved
	task automatic t_wrap();
		t_write(8'h15, 8'h08);
		t_burst(8'h05, 4);
		t_write(8'h15, 8'h00);
		t_burst(8'h06, 2);
	endtask : t_wrap
	task automatic t_live();
		smp = '{16'h1234, 16'h5678, 16'h9ABC};
		pulse_smp();
		smp = '{16'h0F1E, 16'h2D3C, 16'h4B5A};
		sts[0] = 8'h81;
		t_burst(8'h00, 7);
	endtask : t_live
	task automatic t_fifo();
		head = '{16'hA1B2, 16'hC3D4, 16'hE5F6};
		sts[1] = 8'h63;
		for (int m = 1; m < 4; m++) begin
			t_write(8'h09, {m[1:0], 6'h00});
			t_burst(8'h00, 7);
		end
		pulse_smp();
		t_write(8'h09, 8'h00);
		t_burst(8'h00, 7);
	endtask : t_fifo
	task automatic t_writes();
		for (int k = 0; k < 22; k++) t_write(k[7:0], 8'hC3 ^ k[7:0]);
		t_outs();
		t_burst(8'h07, 15);
	endtask : t_writes
	task automatic t_soft();
		soft_rst = 1'b1;
		@(posedge i_sys_clk);
		#1;
		soft_rst = 1'b0;
		foreach (WA[k]) shd[WA[k][4:0]] = 8'h00;
		shd[17] = 8'h01;
		t_outs();
		t_burst(8'h07, 15);
	endtask : t_soft
	initial begin
		i_sys_rst = 1'b1;
		soft_rst = 1'b0;
		smp_vld = 1'b0;
		smp = '{16'h1111, 16'h2222, 16'h3333};
		head = '{16'h4444, 16'h5555, 16'h6666};
		live = '{16'h0000, 16'h0000, 16'h0000};
		sts = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
		foreach (shd[k]) shd[k] = 8'h00;
		shd[17] = 8'h01;
		repeat (10) @(posedge i_sys_clk);
		#1;
		i_sys_rst = 1'b0;
		t_defaults();
		t_reserved();
		t_wrap();
		t_live();
		t_fifo();
		t_writes();
		t_soft();
		close_out();
	end
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end
endmodule : gyr_register_map_autoinc_test

// ===== gyr_regs.svh
// register offsets, field positions and reset values of the rate sensor map
`ifndef GYR_REGS_SVH
`define GYR_REGS_SVH
`define GYR_ADDR_STATUS_ALIAS     8'h00
`define GYR_ADDR_RATE_X_HIGH      8'h01
`define GYR_ADDR_RATE_X_LOW       8'h02
`define GYR_ADDR_RATE_Y_HIGH      8'h03
`define GYR_ADDR_RATE_Y_LOW       8'h04
`define GYR_ADDR_RATE_Z_HIGH      8'h05
`define GYR_ADDR_RATE_Z_LOW       8'h06
`define GYR_ADDR_SAMPLE_READY     8'h07
`define GYR_ADDR_FIFO_STATE       8'h08
`define GYR_ADDR_FIFO_CONFIG      8'h09
`define GYR_ADDR_FIFO_EVENT       8'h0A
`define GYR_ADDR_IRQ_SOURCE       8'h0B
`define GYR_ADDR_IDENTITY         8'h0C
`define GYR_ADDR_CTRL_RANGE       8'h0D
`define GYR_ADDR_THR_CONFIG       8'h0E
`define GYR_ADDR_THR_EVENT        8'h0F
`define GYR_ADDR_THR_LEVEL        8'h10
`define GYR_ADDR_THR_DEBOUNCE     8'h11
`define GYR_ADDR_TEMPERATURE      8'h12
`define GYR_ADDR_CTRL_MODE_RATE   8'h13
`define GYR_ADDR_CTRL_IRQ         8'h14
`define GYR_ADDR_CTRL_INC_POWER   8'h15
`define GYR_ADDR_RESERVED_FIRST   8'h16
`define GYR_RST_DEFAULT           8'h00
`define GYR_RST_THR_DEBOUNCE      8'h01
`define GYR_FIFO_MODE_MSB         7
`define GYR_FIFO_MODE_LSB         6
`define GYR_FIFO_MODE_OFF         2'h0
`define GYR_WRAP_FIRST_BIT        3
`endif
